//--- core/lbw_pkg.sv
// Constants and types of the local bus write port
// Behaviour
// - Address bits 31:4 sit on bus bits 31:4 in the address phase.
// - Four active-low lane strobes on bus bits 3:0, strobe 3 for 31:24.
// - Lane strobes held inactive in reads while their read mask is off.
// - Lane strobes exact for 32-bit ports, union of bytes for narrow ports.
// - Narrow store data on 31:16/15:0 or 31:24/7:0 by endianness.
// - Narrow lanes follow reset endianness; unused data lines may float.
// - Active-high latch strobe lets external latches catch the address.
// - Low address bits 3:2, 3:1 or 3:0 by port, counting per datum.
// - Read drive enable stays high through every write.
// - Same-page hint when bits 31:8 match last write and no read or DMA.
// - Narrow ports give the hint only if the whole burst qualifies.
// - Done ends a single write; in a burst it steps to the next datum.
// - Fault ends the write without done and raises no exception.
// - Half-lane select 1 marks the most significant lane, 0 the least.
// - Half-lane selects held inactive in reads while their mask is off.
// - Mask off: endian half-lane select high in 8-bit reads, low writes.
// - Final flag with store for single writes, after next-to-last done.
// - Memory pulse low 1 clock in, up 1/2 after done, down 1/2 later.
// - Memory pulse enabled for reads and writes by config; writes at reset.
// - Peripheral pulse low two clocks after latch falls, only 3+ cycles.
// - Peripheral pin is input at reset; config makes it an output.
// - Store cycle output low from start until every datum is done or a fault ends it.
package lbw_pkg;

  localparam logic [3:0] CTRL_OFS     = 4'h0;
  localparam logic [3:0] STAT_OFS     = 4'h4;
  localparam int         C_LANE_MASK  = 0;
  localparam int         C_HALF_MASK  = 1;
  localparam int         C_MEM_RD     = 2;
  localparam int         C_MEM_WR     = 3;
  localparam int         C_PER_RD     = 4;
  localparam int         C_PER_WR     = 5;
  localparam int         C_PIN_DIR    = 6;
  localparam logic [6:0] CTRL_RESET   = 7'h08;
  localparam int         S_BUSY       = 0;
  localparam int         S_FAULT      = 1;
  localparam int         S_ENDIAN     = 2;
  localparam int         S_PIN        = 3;
  localparam logic [1:0] SIZE_32      = 2'h0;
  localparam logic [1:0] SIZE_16      = 2'h1;
  localparam logic [1:0] SIZE_8       = 2'h2;
  // Bus clock is two system clock cycles; each half is one cycle
  localparam int         CLK_PERIOD_NS = 5;
  localparam int         BUS_PERIOD_NS = 10;
  localparam int         HALF_CYCLES   = BUS_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [1:0] MEM_LOW_BC    = 2'h1;
  localparam logic [1:0] PER_LOW_BC    = 2'h2;
  localparam logic [1:0] ACK_MIN_BC    = 2'h1;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_ADDR = 3'b010,
    S_DATA = 3'b100
  } state_t;

endpackage : lbw_pkg

//--- core/local_bus_write_port.sv
// Write side of the multiplexed local bus
//
// The plain strobed port and the address map were chosen for this implementation.
module local_bus_write_port
  import lbw_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_wr_req,
  input  wire logic [31:0] i_wr_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic [3:0]  i_wr_be,
  input  wire logic [1:0]  i_port_size,
  input  wire logic        i_rd_cycle,
  input  wire logic [3:0]  i_rd_be,
  input  wire logic        i_dma_cycle,
  input  wire logic        i_big_endian,
  input  wire logic        i_ack_n,
  input  wire logic        i_fault_n,
  input  wire logic        i_periph_in,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic             o_wr_taken,
  output logic             o_bus_clk,
  output logic [31:0]      o_ad,
  output logic             o_ad_oe,
  output logic             o_ale,
  output logic [3:0]       o_addr_lo,
  output logic             o_store_n,
  output logic [3:0]       o_rd_lane_select_word_n,
  output logic [1:0]       o_half_lane_select_n,
  output logic             o_read_drive_enable_n,
  output logic             o_same_page_store_hint_n,
  output logic             o_final_n,
  output logic             o_memory_pulse_n,
  output logic             o_peripheral_pulse_n,
  output logic             o_peripheral_oe,
  output logic [31:0]      o_reg_rdata
);

  // ----------------------------------------------------------------
  // Datum helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] first_one(input logic [3:0] v);
    first_one = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction : first_one

  function automatic logic [1:0] last_one(input logic [3:0] v);
    last_one = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
  endfunction : last_one

  // Half-lane selects for one datum, active low
  function automatic logic [1:0] halves(input logic [1:0] sz,
                                        input logic [3:0] bo,
                                        input logic       be,
                                        input logic [1:0] k);
    logic [1:0] h;
    h = 2'h3;
    if (sz == SIZE_16) begin
      if (be) h = {~bo[{k[0], 1'b0}], ~bo[{k[0], 1'b1}]};
      else    h = {~bo[{k[0], 1'b1}], ~bo[{k[0], 1'b0}]};
    end else if (sz == SIZE_8) begin
      h = be ? 2'h1 : 2'h2;
    end
    halves = h;
  endfunction : halves

  // Store data placed on the endian lane of a narrow port
  function automatic logic [31:0] lanes(input logic [1:0]  sz,
                                        input logic [31:0] d,
                                        input logic        be,
                                        input logic [1:0]  k);
    logic [7:0]  b;
    logic [15:0] w;
    b = be ? d[8 * (3 - k) +: 8] : d[8 * k +: 8];
    w = be ? d[16 * (1 - k[0]) +: 16] : d[16 * k[0] +: 16];
    if (sz == SIZE_8)       lanes = be ? {b, 24'h0} : {24'h0, b};
    else if (sz == SIZE_16) lanes = be ? {w, 16'h0} : {16'h0, w};
    else                    lanes = d;
  endfunction : lanes

  function automatic logic [3:0] low_addr(input logic [1:0] sz,
                                          input logic [3:2] a,
                                          input logic [1:0] k);
    if (sz == SIZE_8)       low_addr = {a, k};
    else if (sz == SIZE_16) low_addr = {a, k[0], 1'b0};
    else                    low_addr = {a, 2'h0};
  endfunction : low_addr

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t      state;
  logic        ph;
  logic [1:0]  bc;
  logic [1:0]  idx;
  logic [1:0]  last_idx;
  logic        gap;
  logic [31:0] w_addr;
  logic [31:0] w_data;
  logic [3:0]  w_bo;
  logic [1:0]  w_size;
  logic [6:0]  ctrl;
  logic        fault_seen;
  logic        big_endian;
  logic [1:0]  strap_cnt;
  logic        strap_m;
  logic        strap_s;
  logic [1:0]  ack_sync;
  logic [1:0]  fault_sync;
  logic [1:0]  pin_sync;
  logic [23:0] prev_page;
  logic        prev_ok;

  logic        start;
  logic        accept;
  logic        finish;
  logic [3:0]  in_bo;
  logic [1:0]  in_first;
  logic [1:0]  in_last;
  logic [1:0]  next_idx;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      in_bo[k] = big_endian ? i_wr_be[3 - k] : i_wr_be[k];
    end
    in_first = 2'h0;
    in_last  = 2'h0;
    if (i_port_size == SIZE_8) begin
      in_first = first_one(in_bo);
      in_last  = last_one(in_bo);
    end else if (i_port_size == SIZE_16) begin
      in_first = (in_bo[1:0] != 2'h0) ? 2'h0 : 2'h1;
      in_last  = (in_bo[3:2] != 2'h0) ? 2'h1 : 2'h0;
    end
  end

  assign start    = (state == S_IDLE) && i_wr_req && ph
                    && !i_rd_cycle && !i_dma_cycle;
  // Done or fault count only on a bus rising edge, cycle two onward
  assign accept   = (state == S_DATA) && ph && (bc >= ACK_MIN_BC)
                    && (!ack_sync[1] || !fault_sync[1]);
  assign finish   = accept && (idx == last_idx || !fault_sync[1]);
  assign next_idx = idx + 2'h1;

  // ----------------------------------------------------------------
  // Pin synchronisers and reset strap
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_sync   <= 2'h3;
      fault_sync <= 2'h3;
      pin_sync   <= 2'h3;
      strap_m    <= 1'b0;
      strap_s    <= 1'b0;
    end else begin
      ack_sync   <= {ack_sync[0], i_ack_n};
      fault_sync <= {fault_sync[0], i_fault_n};
      pin_sync   <= {pin_sync[0], i_periph_in};
      strap_m    <= i_big_endian;
      strap_s    <= strap_m;
    end
  end

  // Endianness frozen once the strap has settled after release
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_cnt  <= 2'h0;
      big_endian <= 1'b0;
    end else if (strap_cnt != 2'h3) begin
      strap_cnt  <= strap_cnt + 2'h1;
      big_endian <= strap_s;
    end
  end

  // ----------------------------------------------------------------
  // Bus clock and sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph        <= 1'b0;
      o_bus_clk <= 1'b0;
    end else begin
      ph        <= ~ph;
      o_bus_clk <= ph;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state      <= S_IDLE;
      bc         <= 2'h0;
      idx        <= 2'h0;
      last_idx   <= 2'h0;
      gap        <= 1'b0;
      o_wr_taken <= 1'b0;
    end else begin
      o_wr_taken <= start;
      unique case (state)
        S_IDLE: begin
          if (start) begin
            state    <= S_ADDR;
            bc       <= 2'h0;
            idx      <= in_first;
            last_idx <= in_last;
          end
        end
        S_ADDR: begin
          state <= S_DATA;
        end
        S_DATA: begin
          gap <= 1'b0;
          if (ph && bc != 2'h3) bc <= bc + 2'h1;
          if (finish) begin
            state <= S_IDLE;
          end else if (accept) begin
            idx <= next_idx;
            gap <= 1'b1;
          end
        end
      endcase
    end
  end

  // Transaction latch, taken when the write starts
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_addr <= 32'h0;
      w_data <= 32'h0;
      w_bo   <= 4'h0;
      w_size <= SIZE_32;
    end else if (start) begin
      w_addr <= i_wr_addr;
      w_data <= i_wr_data;
      w_bo   <= in_bo;
      w_size <= i_port_size;
    end
  end

  // ----------------------------------------------------------------
  // Address, data and datum controls
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ad                 <= 32'h0;
      o_ad_oe              <= 1'b0;
      o_ale                <= 1'b0;
      o_addr_lo            <= 4'h0;
      o_store_n            <= 1'b1;
      o_final_n            <= 1'b1;
      o_half_lane_select_n <= 2'h3;
    end else if (start) begin
      o_ad      <= {i_wr_addr[31:4], ~i_wr_be};
      o_ad_oe   <= 1'b1;
      o_ale     <= 1'b1;
      o_store_n <= 1'b0;
      o_final_n <= (in_first != in_last);
      o_addr_lo <= low_addr(i_port_size, i_wr_addr[3:2], in_first);
      o_half_lane_select_n <= halves(i_port_size, in_bo, big_endian,
                                     in_first);
    end else if (state == S_ADDR) begin
      o_ale <= 1'b0;
      o_ad  <= lanes(w_size, w_data, big_endian, idx);
    end else if (finish) begin
      o_ad_oe              <= 1'b0;
      o_store_n            <= 1'b1;
      o_final_n            <= 1'b1;
      o_half_lane_select_n <= 2'h3;
    end else if (accept) begin
      o_ad      <= lanes(w_size, w_data, big_endian, next_idx);
      o_addr_lo <= low_addr(w_size, w_addr[3:2], next_idx);
      o_final_n <= (next_idx != last_idx);
      o_half_lane_select_n <= halves(w_size, w_bo, big_endian,
                                     next_idx);
    end else if (state == S_IDLE) begin
      // Read engine owns the half-lane pins between writes
      o_half_lane_select_n <= 2'h3;
      if (i_rd_cycle && ctrl[C_HALF_MASK]) begin
        o_half_lane_select_n <= {~(i_rd_be[3] | i_rd_be[1]),
                                 ~(i_rd_be[2] | i_rd_be[0])};
      end
    end
  end

  // Lane strobes handed to the read engine for its address phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_lane_select_word_n <= 4'hF;
    end else begin
      o_rd_lane_select_word_n <= ctrl[C_LANE_MASK] ? ~i_rd_be
                                                   : 4'hF;
    end
  end

  // Memory drivers stay off unless the read engine is active
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_read_drive_enable_n <= 1'b1;
    end else begin
      o_read_drive_enable_n <= !(i_rd_cycle && state == S_IDLE
                                 && !start);
    end
  end

  // ----------------------------------------------------------------
  // Same-page hint
  // ----------------------------------------------------------------
  // A burst never leaves its word, so one page test covers it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_page                <= 24'h0;
      prev_ok                  <= 1'b0;
      o_same_page_store_hint_n <= 1'b1;
    end else if (start) begin
      prev_page                <= i_wr_addr[31:8];
      prev_ok                  <= 1'b1;
      o_same_page_store_hint_n <= !(prev_ok
        && prev_page == i_wr_addr[31:8]);
    end else begin
      if (i_rd_cycle || i_dma_cycle) prev_ok <= 1'b0;
      if (finish) o_same_page_store_hint_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Memory and peripheral pulses
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_memory_pulse_n <= 1'b1;
    end else if (state == S_IDLE) begin
      o_memory_pulse_n <= !(i_rd_cycle && !start
                            && ctrl[C_MEM_RD]);
    end else if (finish) begin
      o_memory_pulse_n <= 1'b1;
    end else if (ctrl[C_MEM_WR]) begin
      if (gap) begin
        o_memory_pulse_n <= 1'b1;
      end else if (state == S_DATA && ph && bc == 2'h0) begin
        o_memory_pulse_n <= 1'b0;
      end else if (state == S_DATA && ph) begin
        o_memory_pulse_n <= 1'b0;
      end
    end
  end

  // Held back to the third cycle so short writes never show it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_peripheral_pulse_n <= 1'b1;
      o_peripheral_oe      <= 1'b0;
    end else begin
      o_peripheral_oe <= ctrl[C_PIN_DIR];
      if (state == S_IDLE) begin
        o_peripheral_pulse_n <= !(i_rd_cycle && !start && ctrl[C_PER_RD]);
      end else if (finish) begin
        o_peripheral_pulse_n <= 1'b1;
      end else if (state == S_DATA && !ph && bc == PER_LOW_BC
                   && ctrl[C_PER_WR]) begin
        o_peripheral_pulse_n <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (i_reg_wr && i_reg_addr == CTRL_OFS) begin
      ctrl <= i_reg_wdata[6:0];
    end
  end

  // A fault in the clearing cycle still sets the flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_seen <= 1'b0;
    end else if (accept && !fault_sync[1]) begin
      fault_seen <= 1'b1;
    end else if (i_reg_wr && i_reg_addr == STAT_OFS
                 && i_reg_wdata[S_FAULT]) begin
      fault_seen <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 32'h0;
    end else begin
      o_reg_rdata <= 32'h0;
      if (i_reg_rd && i_reg_addr == CTRL_OFS) begin
        o_reg_rdata <= {25'h0, ctrl};
      end else if (i_reg_rd && i_reg_addr == STAT_OFS) begin
        o_reg_rdata <= {28'h0, pin_sync[1], big_endian, fault_seen,
                        state != S_IDLE};
      end
    end
  end

endmodule : local_bus_write_port

//--- tb/lbw_checker.sv
// Pin-level assertions for the local bus write port
module lbw_checker
  import lbw_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [31:0] i_wr_addr,
  input wire logic [3:0]  i_wr_be,
  input wire logic [1:0]  i_port_size,
  input wire logic        o_wr_taken,
  input wire logic [31:0] o_ad,
  input wire logic        o_ad_oe,
  input wire logic        o_ale,
  input wire logic [3:0]  o_addr_lo,
  input wire logic        o_store_n,
  input wire logic        o_read_drive_enable_n,
  input wire logic        o_same_page_store_hint_n,
  input wire logic        o_final_n,
  input wire logic        o_memory_pulse_n,
  input wire logic        o_peripheral_pulse_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ------------------------------------------------------------
  // Address phase
  // ------------------------------------------------------------
  addr_word_a:
    assert property (o_ale |-> (o_ad >> 4) == ($past(i_wr_addr) >> 4))
    else $error("address bits wrong");
  lane_strobe_a:
    assert property (o_ale |-> o_ad[3:0] == ~$past(i_wr_be))
    else $error("lane strobes wrong in address phase");
  latch_pulse_a:
    assert property (o_ale |-> o_ad_oe && !o_store_n ##1 !o_ale)
    else $error("latch strobe not one cycle in a store");
  word_low_a:
    assert property (o_ale && $past(i_port_size) == SIZE_32
                     |-> o_addr_lo[1:0] == 2'h0)
    else $error("low address bits set on a word write");
  taken_store_a:
    assert property (o_wr_taken |-> $fell(o_store_n) && o_ale)
    else $error("store did not open with request");
  // ------------------------------------------------------------
  // Data phase and end
  // ------------------------------------------------------------
  drive_off_a:
    assert property (!o_store_n |-> o_read_drive_enable_n)
    else $error("read drive enable low in a write");
  hint_hold_a:
    assert property (!o_store_n && !$fell(o_store_n)
                     |-> $stable(o_same_page_store_hint_n))
    else $error("hint moved inside a write");
  final_off_a:
    assert property (o_store_n |-> o_final_n)
    else $error("final flag low outside a store");
  mem_first_a:
    assert property ($fell(o_store_n) |=> o_memory_pulse_n)
    else $error("memory pulse low before one clock");
  per_late_a:
    assert property ($fell(o_store_n) |=> o_peripheral_pulse_n [*4])
    else $error("peripheral pulse too early");
  bus_free_a:
    assert property ($rose(o_store_n) |-> !o_ad_oe && o_memory_pulse_n)
    else $error("bus or memory pulse active after write");
  single_c: cover property ($fell(o_store_n) && !o_final_n);
  burst_c: cover property (!o_store_n && $fell(o_final_n));
  per_c: cover property ($fell(o_peripheral_pulse_n));
  hint_c: cover property (o_ale && !o_same_page_store_hint_n);
endmodule : lbw_checker

bind local_bus_write_port lbw_checker lbw_checker_i (
  .i_clk, .i_rst_n, .i_wr_addr, .i_wr_be, .i_port_size, .o_wr_taken,
  .o_ad, .o_ad_oe, .o_ale, .o_addr_lo, .o_store_n, .o_read_drive_enable_n,
  .o_same_page_store_hint_n, .o_final_n, .o_memory_pulse_n,
  .o_peripheral_pulse_n
);

//--- tb/lbw_mem_model.sv
// Behavioural memory system answering store cycles
module lbw_mem_model (
  input  wire logic       i_clk,
  input  wire logic       i_store_n,
  input  wire logic [3:0] i_delay,
  input  wire logic       i_fault,
  output logic            o_ack_n,
  output logic            o_fault_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Two low cycles so the synchroniser sees one answer, then pull-ups
  initial begin
    o_ack_n = 1'b1;
    o_fault_n = 1'b1;
    forever begin
      @(posedge i_clk);
      if (!i_store_n) begin
        repeat (i_delay) @(posedge i_clk);
        if (i_fault) o_fault_n <= 1'b0;
        else o_ack_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        o_ack_n <= 1'b1;
        o_fault_n <= 1'b1;
        repeat (3) @(posedge i_clk);
      end
    end
  end
endmodule : lbw_mem_model

//--- tb/local_bus_write_port_tb.sv
// Self-checking bench for the local bus write port
module local_bus_write_port_tb;
  import lbw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] ad; logic hint;} start_t;
  typedef struct {
    logic [3:0]  lo;
    logic [31:0] msk, val;
    logic        fin;
    logic [1:0]  hm, hv;
  } dat_t;
  logic        i_clk, i_rst_n, i_wr_req, i_rd_cycle, i_dma_cycle;
  logic        i_big_endian, i_ack_n, i_fault_n, i_periph_in;
  logic        i_reg_wr, i_reg_rd, o_wr_taken, o_bus_clk, o_ad_oe;
  logic        o_ale, o_store_n, o_read_drive_enable_n, o_final_n;
  logic        o_same_page_store_hint_n, o_memory_pulse_n;
  logic        o_peripheral_pulse_n, o_peripheral_oe;
  logic [31:0] i_wr_addr, i_wr_data, i_reg_wdata, o_ad, o_reg_rdata, a;
  logic [3:0]  i_wr_be, i_rd_be, i_reg_addr, o_addr_lo, dly;
  logic [3:0]  o_rd_lane_select_word_n;
  logic [1:0]  i_port_size, o_half_lane_select_n;
  logic        e, have, brk, seen_per, rd_d, pp, flt;
  logic [23:0] pg;
  int          fails, n_checks;
  start_t      exp_s[$];
  dat_t        exp_d[$];
  logic [31:0] exp_r[$];

  local_bus_write_port local_bus_write_port_i (
    .i_clk, .i_rst_n, .i_wr_req, .i_wr_addr, .i_wr_data, .i_wr_be,
    .i_port_size, .i_rd_cycle, .i_rd_be, .i_dma_cycle, .i_big_endian,
    .i_ack_n, .i_fault_n, .i_periph_in, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .o_wr_taken, .o_bus_clk, .o_ad, .o_ad_oe,
    .o_ale, .o_addr_lo, .o_store_n, .o_rd_lane_select_word_n,
    .o_half_lane_select_n, .o_read_drive_enable_n,
    .o_same_page_store_hint_n, .o_final_n, .o_memory_pulse_n,
    .o_peripheral_pulse_n, .o_peripheral_oe, .o_reg_rdata);
  lbw_mem_model lbw_mem_model_i (.i_clk, .i_store_n(o_store_n),
    .i_delay(dly), .i_fault(flt), .o_ack_n(i_ack_n), .o_fault_n(i_fault_n));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task test_done;
    $display("Checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  task timeout(string nm);
    fails++;
    $display("CHECK FAILED %s expected done seen timeout", nm);
    test_done;
  endtask : timeout

  // ------------------------------------------------------------
  // Scoreboard: notes are taken off as the pins show results
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    if (o_ale) begin
      chk("addr word", o_ad, exp_s[0].ad);
      chk("bus clk", {31'h0, o_bus_clk}, 32'h1);
      chk("hint", {31'h0, o_same_page_store_hint_n},
          {31'h0, exp_s[0].hint});
      exp_s.delete(0);
    end
    if (pp && !o_memory_pulse_n) begin
      chk("data", o_ad & exp_d[0].msk, exp_d[0].val);
      chk("addr lo", {28'h0, o_addr_lo}, {28'h0, exp_d[0].lo});
      chk("final", {31'h0, o_final_n}, {31'h0, exp_d[0].fin});
      chk("half", {30'h0, o_half_lane_select_n & exp_d[0].hm},
          {30'h0, exp_d[0].hv});
      exp_d.delete(0);
    end
    pp = o_memory_pulse_n;
    if (!o_peripheral_pulse_n) seen_per = 1'b1;
    if (rd_d) begin
      chk("reg data", o_reg_rdata, exp_r[0]);
      exp_r.delete(0);
    end
    rd_d = i_reg_rd;
  end

  task wreg(logic [3:0] ad, logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr <= ad;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : wreg

  task rd(logic [3:0] ad, logic [31:0] x);
    exp_r.push_back(x);
    @(posedge i_clk);
    i_reg_addr <= ad;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
  endtask : rd

  task rdmask(logic [3:0] lw, logic [1:0] hm, logic [1:0] hw);
    @(posedge i_clk);
    i_rd_cycle <= 1'b1;
    i_rd_be <= 4'h5;
    repeat (4) @(posedge i_clk);
    chk("rd lanes", {28'h0, o_rd_lane_select_word_n}, {28'h0, lw});
    chk("rd half", {30'h0, o_half_lane_select_n & hm}, {30'h0, hw});
    i_rd_cycle <= 1'b0;
    brk = 1'b1;
  endtask : rdmask

  task automatic wr(logic [31:0] ad, logic [31:0] d, logic [3:0] be,
                    logic [1:0] sz, logic [3:0] dl, logic f);
    start_t s;
    dat_t t;
    int ln, i, k;
    s.ad = {ad[31:4], ~be};
    s.hint = !(have && ad[31:8] == pg && !brk);
    exp_s.push_back(s);
    have = 1'b1;
    pg = ad[31:8];
    brk = 1'b0;
    t.fin = 1'b1;
    for (k = 0; k < 4; k++) begin
      ln = e ? 3 - k : k;
      t.lo = {ad[3:2], 2'(k)};
      t.hm = 2'h3;
      t.hv = 2'h3;
      if (sz == SIZE_32 && k == 0) begin
        t.lo[1:0] = 2'h0;
        t.msk = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        t.val = d & t.msk;
        exp_d.push_back(t);
      end
      if (sz == SIZE_16 && k < 2) begin
        t.lo[1:0] = {k[0], 1'b0};
        t.msk = e ? 32'hFFFF0000 : 32'h0000FFFF;
        t.val = e ? {d[16*(1-k) +: 16], 16'h0} : {16'h0, d[16*k +: 16]};
        t.hv = 2'h0;
        exp_d.push_back(t);
      end
      if (sz == SIZE_8 && be[ln]) begin
        t.msk = e ? 32'hFF000000 : 32'h000000FF;
        t.val = e ? {d[8*ln +: 8], 24'h0} : {24'h0, d[8*ln +: 8]};
        t.hm = e ? 2'h2 : 2'h1;
        t.hv = 2'h0;
        exp_d.push_back(t);
      end
    end
    exp_d[exp_d.size() - 1].fin = 1'b0;
    @(posedge i_clk);
    dly <= dl;
    flt <= f;
    i_wr_addr <= ad;
    i_wr_data <= d;
    i_wr_be <= be;
    i_port_size <= sz;
    i_wr_req <= 1'b1;
    for (i = 0; i < 10 && o_wr_taken !== 1'b1; i++) @(posedge i_clk);
    if (i == 10) timeout("write start");
    i_wr_req <= 1'b0;
    for (i = 0; i < 300 && o_store_n !== 1'b1; i++) @(posedge i_clk);
    if (i == 300) timeout("write end");
    chk("datum count", 32'(exp_d.size()), 32'h0);
  endtask : wr

  // ------------------------------------------------------------
  // Main sequence, once per reset endianness
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h89D4));
    {i_wr_req, i_rd_cycle, i_dma_cycle, i_reg_wr, i_reg_rd, flt} = '0;
    {i_wr_addr, i_wr_data, i_reg_wdata, i_wr_be, i_rd_be} = '0;
    {i_port_size, i_reg_addr, rd_d, seen_per, i_rst_n} = '0;
    {i_periph_in, i_big_endian, pp, dly} = {3'h7, 4'h1};
    fails = 0;
    n_checks = 0;
    for (int p = 0; p < 2; p++) begin
      e = (p == 0);
      have = 1'b0;
      i_big_endian <= e;
      i_rst_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      chk("pin oe", {31'h0, o_peripheral_oe}, 32'h0);
      chk("rd drive", {31'h0, o_read_drive_enable_n}, 32'h1);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      rd(CTRL_OFS, 32'(CTRL_RESET));
      rd(STAT_OFS, {28'h0, 1'b1, e, 2'h0});
      wreg(4'hC, 32'hFFFFFFFF);
      rd(4'h8, 32'h0);
      rd(CTRL_OFS, 32'(CTRL_RESET));
      wreg(CTRL_OFS, 32'h6B);
      repeat (3) @(posedge i_clk);
      chk("pin oe", {31'h0, o_peripheral_oe}, 32'h1);
      a = $urandom & 32'hFFFFFFFC;
      wr(a, $urandom, 4'($urandom_range(1, 15)), SIZE_32, 4'h1, 1'b0);
      wr({a[31:8], 8'($urandom) & 8'hFC}, $urandom,
         4'($urandom_range(1, 15)), SIZE_32, 4'h2, 1'b0);
      rdmask(4'hA, 2'h3, 2'h2);
      wr(a, $urandom, 4'hF, SIZE_16, 4'h1, 1'b0);
      seen_per = 1'b0;
      wr(a, $urandom, 4'hF, SIZE_8, 4'h4, 1'b0);
      chk("periph pulse", {31'h0, seen_per}, 32'h1);
      @(posedge i_clk);
      i_dma_cycle <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_dma_cycle <= 1'b0;
      brk = 1'b1;
      wr(a, $urandom, 4'(1 << $urandom_range(0, 3)), SIZE_8, 4'h1, 1'b0);
      repeat (3) wr($urandom & 32'hFFFFFFFC, $urandom, 4'hF, SIZE_32,
                    4'($urandom_range(1, 3)), 1'b0);
      wr(a, $urandom, 4'hF, SIZE_32, 4'h3, 1'b1);
      rd(STAT_OFS, {28'h0, 1'b1, e, 2'h2});
      wreg(STAT_OFS, 32'h2);
      rd(STAT_OFS, {28'h0, 1'b1, e, 2'h0});
      wreg(CTRL_OFS, 32'h08);
      rdmask(4'hF, 2'h3, 2'h3);
      repeat (4) @(posedge i_clk);
    end
    test_done;
  end
endmodule : local_bus_write_port_tb
